// ### hw/hlc_coupling_core.v
/*
 one high-side coupling cell: ground reference active from a low-side mask,
 the low-side on-states and a disable bit.
 assumes mask, disable and low-side states are synchronous to the system clock.
*/
`include "hlc_defs.vh"

module hlc_coupling_core
(
   input wire [`HLC_MASK_W-1:0] share_mask,
   input wire coupling_disable,
   input wire disabled_level,
   input wire [`HLC_MASK_W-1:0] ls_on,
   output wire ground_ref_active
);

   wire any_shared_on;

   // or of the selected low sides, purely combinational
   assign any_shared_on = |(share_mask & ls_on);

   // disable overrides the low-side states entirely
   assign ground_ref_active = coupling_disable ? disabled_level : any_shared_on;

endmodule

// ### hw/hlc_defs.vh
/*
 constants for the high-side / low-side coupling block: register indices,
 field positions, reset values and widths.
 assumes inclusion by bare name from the design files under hw/.
*/
`ifndef HLC_DEFS_VH
`define HLC_DEFS_VH

// register indices; byte address is four times the index
`define HLC_IDX_HS12 10'h01a6
`define HLC_IDX_HS34 10'h01a7
`define HLC_IDX_HS5 10'h01a8
`define HLC_IDX_STATUS 10'h01b0

`define HLC_ADDR_W 12
`define HLC_DATA_W 32
`define HLC_REG_W 16
`define HLC_BYTE_W 8
`define HLC_WORD_LSB 2
`define HLC_ALIGN_OK 2'h0

// per high-side byte layout
`define HLC_MASK_LSB 0
`define HLC_MASK_MSB 6
`define HLC_MASK_W 7
`define HLC_DIS_BIT 7

// byte lanes of the 16-bit registers
`define HLC_LO_LSB 0
`define HLC_LO_MSB 7
`define HLC_HI_LSB 8
`define HLC_HI_MSB 15

// status layout
`define HLC_ST_ACT_LSB 0
`define HLC_ST_ACT_MSB 4
`define HLC_ST_EXIT_LSB 8
`define HLC_ST_EXIT_MSB 12

`define HLC_NUM_HS 5
`define HLC_NUM_LS 7

// reset values: masks all one, disable bits zero, reserved byte zero
`define HLC_RST_PAIR 16'h7f7f
`define HLC_RST_SINGLE 8'h7f
`define HLC_RST_EXIT 5'h00
`define HLC_RDATA_ZERO 32'h0000_0000
`define HLC_ZERO_BYTE 8'h00
`define HLC_ZERO_PAD 16'h0000
`define HLC_ZERO_3 3'h0

`endif

// ### hw/hlc_top.v
/*
 high-side / low-side coupling block with its apb register slave: five
 ground-reference-active signals, and a sticky bootstrap-init exit per high side.
 assumes the apb master and the low-side on-states run on pclk.
*/
// Contract
// - each high side's ground reference is active when any masked low side is on.
// - a set disable bit on high side three, four or five forces its signal to one.
// - the disabled level of high sides one and two is a choice, one by default.
// - the first register holds high side one in bits 7:0 and two in 15:8.
// - the second register holds high side three in bits 7:0 and four in 15:8.
// - the third register holds high side five in bits 7:0, bits 15:8 reserved zero.
// - a high side leaves bootstrap init once its ground reference goes to one.
`include "hlc_defs.vh"

module hlc_top
#(
   parameter HS12_DISABLED_LEVEL = 1'b1
)
(
   input wire pclk,
   input wire presetn,
   input wire [`HLC_ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`HLC_DATA_W-1:0] pwdata,
   output wire [`HLC_DATA_W-1:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [`HLC_NUM_LS-1:0] ls_on,
   output wire [`HLC_NUM_HS-1:0] ground_ref_active,
   output wire [`HLC_NUM_HS-1:0] bs_init_exited
);

   // register storage
   reg [`HLC_REG_W-1:0] hs_one_two_low_side_coupling_q;
   reg [`HLC_REG_W-1:0] hs_one_two_low_side_coupling_d;
   reg [`HLC_REG_W-1:0] hs_three_four_low_side_coupling_q;
   reg [`HLC_REG_W-1:0] hs_three_four_low_side_coupling_d;
   reg [`HLC_BYTE_W-1:0] hs_five_low_side_coupling_q;
   reg [`HLC_BYTE_W-1:0] hs_five_low_side_coupling_d;
   reg [`HLC_NUM_HS-1:0] init_exit_q;
   reg [`HLC_NUM_HS-1:0] init_exit_d;
   reg [`HLC_DATA_W-1:0] prdata_q;
   reg [`HLC_DATA_W-1:0] prdata_d;

   wire setup_phase;
   wire access_phase;
   wire wr_en;
   wire hit_hs12;
   wire hit_hs34;
   wire hit_hs5;
   wire hit_status;
   wire hit_any;

   // per high side unpacked fields
   wire [`HLC_MASK_W*`HLC_NUM_HS-1:0] mask_flat;
   wire [`HLC_NUM_HS-1:0] dis_vec;
   wire [`HLC_NUM_HS-1:0] dis_level_vec;

   // word aligned index match; unaligned addresses are unmapped
   function addr_hit;
      input [`HLC_ADDR_W-1:0] addr;
      input [`HLC_ADDR_W-3:0] idx;
      begin
         addr_hit = (addr[`HLC_ADDR_W-1:`HLC_WORD_LSB] == idx) &&
            (addr[`HLC_WORD_LSB-1:0] == `HLC_ALIGN_OK);
      end
   endfunction

   // merge a written byte lane: mask in low bits, disable on top
   function [`HLC_BYTE_W-1:0] lane;
      input [`HLC_BYTE_W-1:0] wdata;
      begin
         lane = {wdata[`HLC_DIS_BIT], wdata[`HLC_MASK_MSB:`HLC_MASK_LSB]};
      end
   endfunction

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;

   // zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign wr_en = access_phase & pwrite & hit_any;

   assign hit_hs12 = addr_hit(paddr, `HLC_IDX_HS12);
   assign hit_hs34 = addr_hit(paddr, `HLC_IDX_HS34);
   assign hit_hs5 = addr_hit(paddr, `HLC_IDX_HS5);
   assign hit_status = addr_hit(paddr, `HLC_IDX_STATUS);
   assign hit_any = hit_hs12 | hit_hs34 | hit_hs5 | hit_status;

   // unmapped addresses answer with an error, writes there change nothing
   assign pslverr = access_phase & ~hit_any;

   // write next-state
   always @*
   begin
      hs_one_two_low_side_coupling_d = hs_one_two_low_side_coupling_q;
      hs_three_four_low_side_coupling_d = hs_three_four_low_side_coupling_q;
      hs_five_low_side_coupling_d = hs_five_low_side_coupling_q;
      if (wr_en && hit_hs12)
      begin
         hs_one_two_low_side_coupling_d[`HLC_LO_MSB:`HLC_LO_LSB] =
            lane(pwdata[`HLC_LO_MSB:`HLC_LO_LSB]);
         hs_one_two_low_side_coupling_d[`HLC_HI_MSB:`HLC_HI_LSB] =
            lane(pwdata[`HLC_HI_MSB:`HLC_HI_LSB]);
      end
      if (wr_en && hit_hs34)
      begin
         hs_three_four_low_side_coupling_d[`HLC_LO_MSB:`HLC_LO_LSB] =
            lane(pwdata[`HLC_LO_MSB:`HLC_LO_LSB]);
         hs_three_four_low_side_coupling_d[`HLC_HI_MSB:`HLC_HI_LSB] =
            lane(pwdata[`HLC_HI_MSB:`HLC_HI_LSB]);
      end
      if (wr_en && hit_hs5)
      begin
         // reserved upper byte has no storage at all
         hs_five_low_side_coupling_d = lane(pwdata[`HLC_LO_MSB:`HLC_LO_LSB]);
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hs_one_two_low_side_coupling_q <= `HLC_RST_PAIR;
         hs_three_four_low_side_coupling_q <= `HLC_RST_PAIR;
         hs_five_low_side_coupling_q <= `HLC_RST_SINGLE;
      end
      else
      begin
         hs_one_two_low_side_coupling_q <= hs_one_two_low_side_coupling_d;
         hs_three_four_low_side_coupling_q <= hs_three_four_low_side_coupling_d;
         hs_five_low_side_coupling_q <= hs_five_low_side_coupling_d;
      end
   end

   // field unpacking, high side one at index 0
   assign mask_flat = {
      hs_five_low_side_coupling_q[`HLC_MASK_MSB:`HLC_MASK_LSB],
      hs_three_four_low_side_coupling_q[`HLC_HI_LSB+`HLC_MASK_MSB:`HLC_HI_LSB],
      hs_three_four_low_side_coupling_q[`HLC_MASK_MSB:`HLC_MASK_LSB],
      hs_one_two_low_side_coupling_q[`HLC_HI_LSB+`HLC_MASK_MSB:`HLC_HI_LSB],
      hs_one_two_low_side_coupling_q[`HLC_MASK_MSB:`HLC_MASK_LSB]};

   assign dis_vec = {
      hs_five_low_side_coupling_q[`HLC_DIS_BIT],
      hs_three_four_low_side_coupling_q[`HLC_HI_LSB+`HLC_DIS_BIT],
      hs_three_four_low_side_coupling_q[`HLC_DIS_BIT],
      hs_one_two_low_side_coupling_q[`HLC_HI_LSB+`HLC_DIS_BIT],
      hs_one_two_low_side_coupling_q[`HLC_DIS_BIT]};

   // conflicting disabled level for hs1/hs2 kept as a parameter
   assign dis_level_vec = {1'b1, 1'b1, 1'b1, HS12_DISABLED_LEVEL[0], HS12_DISABLED_LEVEL[0]};

   genvar g;
   generate
      for (g = 0; g < `HLC_NUM_HS; g = g + 1)
      begin : g_hs
         hlc_coupling_core u_core
         (
            .share_mask(mask_flat[g*`HLC_MASK_W +: `HLC_MASK_W]),
            .coupling_disable(dis_vec[g]),
            .disabled_level(dis_level_vec[g]),
            .ls_on(ls_on),
            .ground_ref_active(ground_ref_active[g])
         );
      end
   endgenerate

   // init exit is sticky until reset; a later drop of the signal does not re-enter
   always @*
   begin
      init_exit_d = init_exit_q | ground_ref_active;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_exit_q <= `HLC_RST_EXIT;
      end
      else
      begin
         init_exit_q <= init_exit_d;
      end
   end

   assign bs_init_exited = init_exit_q;

   // read mux, captured in setup so prdata comes from a flop
   always @*
   begin
      prdata_d = prdata_q;
      if (setup_phase && !pwrite)
      begin
         prdata_d = `HLC_RDATA_ZERO;
         if (hit_hs12)
         begin
            prdata_d = {`HLC_ZERO_PAD, hs_one_two_low_side_coupling_q};
         end
         else if (hit_hs34)
         begin
            prdata_d = {`HLC_ZERO_PAD, hs_three_four_low_side_coupling_q};
         end
         else if (hit_hs5)
         begin
            prdata_d = {`HLC_ZERO_PAD, `HLC_ZERO_BYTE, hs_five_low_side_coupling_q};
         end
         else if (hit_status)
         begin
            prdata_d[`HLC_ST_ACT_MSB:`HLC_ST_ACT_LSB] = ground_ref_active;
            prdata_d[`HLC_ST_EXIT_MSB:`HLC_ST_EXIT_LSB] = init_exit_q;
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= `HLC_RDATA_ZERO;
      end
      else
      begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;

endmodule

// ### verif/hlc_top_properties.sv
/* checker of the hlc_top apb map and coupling outputs.
 sees only the top ports; bound to hlc_top after the module. */
`include "hlc_defs.vh"
module hlc_chk #(parameter HS12_DISABLED_LEVEL = 1'b1)
(
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [6:0] ls_on,
   input wire [4:0] ground_ref_active,
   input wire [4:0] bs_init_exited
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cfg_q [3];
   logic [4:0] ex;
   wire acc = psel && penable && pready;
   wire [11:0] off = paddr - 12'h698;
   wire hit = paddr[1:0] == 2'h0 && off < 12'h00c;
   wire map = hit || paddr == 12'h6c0;
   wire [39:0] b = {cfg_q[2][7:0], cfg_q[1], cfg_q[0]};
   wire [4:0] dis = {b[39], b[31], b[23], b[15], b[7]};
   // shadow of the writes, so outputs can be tied to register state
   always_comb
   begin
      for (int i = 0; i < 5; i++)
         ex[i] = dis[i] ? (i < 2 ? HS12_DISABLED_LEVEL : 1'b1) : |(b[8*i+:7] & ls_on);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_q[0] <= 16'h7f7f;
         cfg_q[1] <= 16'h7f7f;
         cfg_q[2] <= 16'h007f;
      end
      else if (acc && pwrite && hit)
         cfg_q[off[3:2]] <= off[3] ? {8'h00, pwdata[7:0]} : pwdata[15:0];
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_rd(h);
      psel && !penable && !pwrite && h ##1 acc;
   endsequence
   AST_GRA_OR: assert property ((ground_ref_active & ~dis) == (ex & ~dis))
      else $error("masked or mismatch");
   AST_GRA_DIS: assert property ((ground_ref_active & dis) == (ex & dis))
      else $error("disabled level mismatch");
   AST_EXIT: assert property (1'b1 |=> bs_init_exited ==
      ($past(bs_init_exited) | $past(ground_ref_active))) else $error("init exit mismatch");
   AST_RD_CFG: assert property (s_rd(hit) |-> prdata == {16'h0000, cfg_q[off[3:2]]})
      else $error("config read mismatch");
   AST_RD_ST: assert property (s_rd(paddr == 12'h6c0) |-> prdata ==
      {16'h0000, 3'h0, $past(bs_init_exited), 3'h0, $past(ground_ref_active)})
      else $error("status read mismatch");
   AST_RD_BAD: assert property (s_rd(!map) |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_ERR: assert property (acc && !map |-> pslverr)
      else $error("no error on unmapped");
   AST_NOERR: assert property (acc && map |-> !pslverr)
      else $error("error on mapped");
endmodule
bind hlc_top hlc_chk #(.HS12_DISABLED_LEVEL(HS12_DISABLED_LEVEL)) u_chk (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ls_on(ls_on),
   .ground_ref_active(ground_ref_active), .bs_init_exited(bs_init_exited));

// ### verif/hlc_top_tb_top.sv
/* bench of hlc_top: apb accesses, random masks and low-side states.
 assumes hs1/hs2 disabled level one in uut; a second instance is built with zero. */
module hlc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd;
   logic [6:0] ls_on = 7'h00;
   logic [39:0] sh = 40'h7f_7f7f_7f7f;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [4:0] gra, ex, gra_lvl0;
   int n_errors = 0, n_tests = 0;
   hlc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ls_on(ls_on), .ground_ref_active(gra),
      .bs_init_exited(ex));
   // same bus and low sides, other build choice for the hs1/hs2 disabled level
   hlc_top #(.HS12_DISABLED_LEVEL(1'b0)) uut_lvl0 (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .ls_on(ls_on), .ground_ref_active(gra_lvl0),
      .bs_init_exited());
   initial forever #12.5 pclk = ~pclk;
   function automatic logic [4:0] f_gra(logic [39:0] b, logic [6:0] l, logic lv);
      for (int i = 0; i < 5; i++)
         f_gra[i] = b[8*i+7] ? (i < 2 ? lv : 1'b1) : |(b[8*i+:7] & l);
   endfunction
   function automatic logic [31:0] f_rd(int k);
      f_rd = k == 0 ? sh[15:0] : k == 1 ? sh[31:16] : sh[39:32];
   endfunction
   task give_verdict;
      if (n_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk_w(logic [31:0] g, logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task chk_v(logic [4:0] g, logic [4:0] e);
      chk_w(32'(g), 32'(e));
   endtask
   // starts just after a rising edge; idle cycle at the end avoids double drive
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      forever
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
         n++;
         if (n > 20)
         begin
            n_errors++;
            give_verdict;
         end
      end
      // answer taken at the very edge that completes the access
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task wr(int k, logic [31:0] d);
      apb(1, 12'h698 + 12'(4 * k), d);
      case (k)
         0: sh[15:0] = d[15:0];
         1: sh[31:16] = d[15:0];
         default: sh[39:32] = d[7:0];
      endcase
   endtask
   initial
   begin
      logic [31:0] d;
      void'($urandom(32'hca52));
      for (int r = 0; r < 2; r++)
      begin
         presetn <= 0;
         ls_on <= 7'h00;
         repeat (8) @(posedge pclk);
         presetn <= 1;
         sh = 40'h7f_7f7f_7f7f;
         @(posedge pclk);
         chk_v(ex, 5'h00);
         for (int k = 0; k < 3; k++)
         begin
            apb(0, 12'h698 + 12'(4 * k), 32'h0000_0000);
            chk_w(rd, f_rd(k));
         end
         if (r == 1)
            break;
         // corners first: all clear, then all set, then random
         for (int i = 0; i < 45; i++)
         begin
            d = i < 3 ? 32'h0000_0000 : i < 6 ? 32'hffff_ffff : $urandom;
            wr(i % 3, d);
            ls_on <= 7'($urandom);
            @(negedge pclk);
            chk_v(gra, f_gra(sh, ls_on, 1'b1));
            chk_v(gra_lvl0, f_gra(sh, ls_on, 1'b0));
            @(posedge pclk);
            apb(0, 12'h698 + 12'(4 * (i % 3)), 32'h0000_0000);
            chk_w(rd, f_rd(i % 3));
         end
         apb(1, 12'h699, 32'hffff_ffff);
         chk_w(32'(er), 32'h0000_0001);
         apb(0, 12'h6a4, 32'h0000_0000);
         chk_w({rd[30:0], er}, 32'h0000_0001);
         apb(0, 12'h698, 32'h0000_0000);
         chk_w(rd, f_rd(0));
      end
      wr(1, 32'h0000_8000);
      // exit flag lands one edge after the signal rises
      @(negedge pclk);
      chk_v(ex, 5'h08);
      @(posedge pclk);
      apb(0, 12'h6c0, 32'h0000_0000);
      chk_w(rd, 32'h0000_0808);
      give_verdict;
   end
endmodule
